//--- rtl/nps_pkg.sv
// Package with register map, field layout, reset values and carrier types of the Nco_phase_sync_control block.
package nps_pkg;

	// Byte addresses of the register port; the divisor spans two byte locations, low byte first.
	localparam logic [15:0] NPS_ADDR_RDIV_LO = 16'h0217;
	localparam logic [15:0] NPS_ADDR_RDIV_HI = 16'h0218;
	localparam logic [15:0] NPS_ADDR_SYNC = 16'h0219;

	// Reset values.
	localparam logic [15:0] NPS_RDIV_RESET = 16'h0000;
	localparam logic [7:0] NPS_SYNC_RESET = 8'h02;

	// Field positions inside the phase sync control byte.
	localparam int NPS_SYNC_NEXT_BIT = 0;
	localparam int NPS_SYNC_ILA_BIT = 1;

	// Left-justification shift of the 16-bit phase offset into the 32-bit phase.
	localparam int NPS_PHASE_SHIFT = 16;

	// Progress of the zero-then-one arming sequence for SYSREF-based phase init.
	typedef enum logic [1:0] {
		NPS_ARM_IDLE = 2'b00,
		NPS_ARM_ZERO_SEEN = 2'b01,
		NPS_ARM_ARMED = 2'b10
	} nps_arm_e;

	// One register port request, valid for one cycle.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} nps_reg_req_s;

	// Active NCO preset settings supplied by the preset selection logic.
	typedef struct packed {
		logic [31:0] frequency_word;
		logic [15:0] phase_offset;
	} nps_nco_cfg_s;

endpackage

//--- rtl/nps_phase_acc.sv
// Phase accumulator of one NCO with optional reference-divisor wrap.
`timescale 1ns/1ps

module nps_phase_acc
(
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic init_i,
	input wire logic [15:0] rdiv_i,
	input wire nps_pkg::nps_nco_cfg_s cfg_i,
	output logic [31:0] phase_o
);

	typedef struct packed {
		logic [31:0] acc;
		logic [15:0] cnt;
		logic [31:0] phase;
	} nps_acc_state_s;

	nps_acc_state_s state_reg;
	nps_acc_state_s state_next;
	logic [31:0] offset_ext;

	// The offset is left-justified so that a full 16-bit turn maps to a full 32-bit turn.
	assign offset_ext = {cfg_i.phase_offset, 16'h0000};

	// With a divisor the accumulator restarts every rdiv samples, which makes the period exact;
	// with zero it free-runs as a plain 32-bit accumulator.
	always_comb
	begin
		state_next = state_reg;
		if (init_i)
		begin
			state_next.acc = 32'h00000000;
			state_next.cnt = 16'h0000;
		end
		// Compare with >= so that a divisor lowered below the running count wraps at once
		// instead of counting through the whole 16-bit range first.
		else if (rdiv_i != 16'h0000 && state_reg.cnt >= rdiv_i - 16'h0001)
		begin
			state_next.acc = 32'h00000000;
			state_next.cnt = 16'h0000;
		end
		else
		begin
			state_next.acc = state_reg.acc + cfg_i.frequency_word;
			state_next.cnt = (rdiv_i == 16'h0000) ? 16'h0000 : state_reg.cnt + 16'h0001;
		end
		state_next.phase = state_next.acc + offset_ext;
	end

	// State register.
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign phase_o = state_reg.phase;

	// Plain accumulator steps by the frequency word when the divisor is zero.
	property p_plain_step;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(rdiv_i == 16'h0000 && !init_i && $stable(cfg_i.phase_offset) && $past(nrst_i))
		|=> (phase_o == $past(phase_o) + $past(cfg_i.frequency_word));
	endproperty
	a_plain_step: assert property (p_plain_step) else $error("plain NCO step wrong");

	// Init puts exactly the left-justified offset on the phase.
	property p_init_offset;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		init_i |=> (phase_o == {$past(cfg_i.phase_offset), 16'h0000});
	endproperty
	a_init_offset: assert property (p_init_offset) else $error("init phase not offset");

	// While the divisor holds steady, the sample counter never reaches it.
	property p_cnt_bound;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(rdiv_i != 16'h0000 && $stable(rdiv_i)) |-> (state_reg.cnt < rdiv_i);
	endproperty
	a_cnt_bound: assert property (p_cnt_bound) else $error("divisor count overrun");

	c_div_wrap: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
		rdiv_i != 16'h0000 && state_reg.cnt == rdiv_i - 16'h0001);

endmodule

//--- rtl/nps_nco_phase_sync_control.sv
// Reference divisor and NCO phase synchronisation control with its register port.
`timescale 1ns/1ps

// Behaviour
// - Divisor zero means the NCO runs as a plain 32-bit phase accumulator.
// - One 16-bit divisor serves every NCO preset.
// - With sync-request init set, phase inits at the boundary after SYNC~ rises.
// - SYNC~ init works in both encodings; in 64b/66b SYNC~ leaves the link alone.
// - Writing zero then one to the arm bit arms init on the next SYSREF rise.
// - After a SYSREF init, further SYSREF edges are ignored until re-armed.
// - SYSREF source pulses once or more; only the first rise inits the NCO.
// - The 16-bit phase offset is left-justified into 32 bits and added.
module nps_nco_phase_sync_control
(
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire nps_pkg::nps_reg_req_s reg_req_i,
	input wire logic sync_n_i,
	input wire logic sysref_i,
	input wire logic lmfc_boundary_i,
	input wire logic encoding_64b66b_i,
	input wire nps_pkg::nps_nco_cfg_s nco_cfg_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	output logic [31:0] phase_o,
	output logic phase_init_o,
	output logic sync_armed_o,
	output logic link_sync_request_o
);

	typedef struct packed {
		logic [15:0] nco_reference_divisor;
		logic phase_init_on_sync_request;
		logic phase_init_on_next_sysref;
		nps_pkg::nps_arm_e arm;
		logic armed;
		logic sync_prev;
		logic sysref_prev;
		logic sync_pending;
		logic phase_init;
		logic link_sync_request;
		logic [7:0] rdata;
		logic rvalid;
	} nps_main_state_s;

	nps_main_state_s state_reg;
	nps_main_state_s state_next;
	logic wr_sync;
	logic sync_rise;
	logic sysref_rise;
	logic init_sync;
	logic init_sysref;

	// Edge detection and the two init sources; the pins are synchronous to the clock.
	assign wr_sync = reg_req_i.wr && reg_req_i.addr == nps_pkg::NPS_ADDR_SYNC;
	assign sync_rise = sync_n_i && !state_reg.sync_prev;
	assign sysref_rise = sysref_i && !state_reg.sysref_prev;
	assign init_sync = state_reg.phase_init_on_sync_request && state_reg.sync_pending
		&& lmfc_boundary_i;
	// A rise that meets an arm-bit write is ignored, so the arm is never used twice.
	assign init_sysref = (state_reg.arm == nps_pkg::NPS_ARM_ARMED) && sysref_rise
		&& !wr_sync;

	// Next-state logic for registers, arming sequence, pending sync and read data.
	always_comb
	begin
		state_next = state_reg;
		state_next.sync_prev = sync_n_i;
		state_next.sysref_prev = sysref_i;
		state_next.rvalid = reg_req_i.rd;
		state_next.rdata = 8'h00;
		// A rise in the same cycle as a boundary waits for the next boundary, since init
		// must follow the rise; the set beats the clear.
		state_next.sync_pending = state_reg.phase_init_on_sync_request
			&& (sync_rise || (state_reg.sync_pending && !lmfc_boundary_i));
		state_next.phase_init = init_sync || init_sysref;
		// SYSREF init reaches only the NCO; the link request follows SYNC~ only in 8b/10b.
		state_next.link_sync_request = !encoding_64b66b_i && !sync_n_i;
		if (reg_req_i.wr)
		begin
			unique case (reg_req_i.addr)
				nps_pkg::NPS_ADDR_RDIV_LO:
					state_next.nco_reference_divisor[7:0] = reg_req_i.wdata;
				nps_pkg::NPS_ADDR_RDIV_HI:
					state_next.nco_reference_divisor[15:8] = reg_req_i.wdata;
				nps_pkg::NPS_ADDR_SYNC:
				begin
					state_next.phase_init_on_sync_request =
						reg_req_i.wdata[nps_pkg::NPS_SYNC_ILA_BIT];
					state_next.phase_init_on_next_sysref =
						reg_req_i.wdata[nps_pkg::NPS_SYNC_NEXT_BIT];
				end
				default:
				begin
				end
			endcase
		end
		// Arming needs an explicit zero write followed by a one write; a bare one does nothing.
		unique case (state_reg.arm)
			nps_pkg::NPS_ARM_IDLE:
			begin
				if (wr_sync && !reg_req_i.wdata[nps_pkg::NPS_SYNC_NEXT_BIT])
					state_next.arm = nps_pkg::NPS_ARM_ZERO_SEEN;
			end
			nps_pkg::NPS_ARM_ZERO_SEEN:
			begin
				if (wr_sync && reg_req_i.wdata[nps_pkg::NPS_SYNC_NEXT_BIT])
					state_next.arm = nps_pkg::NPS_ARM_ARMED;
			end
			nps_pkg::NPS_ARM_ARMED:
			begin
				// A one written in the consuming cycle keeps the arm: set wins over clear.
				if (wr_sync && !reg_req_i.wdata[nps_pkg::NPS_SYNC_NEXT_BIT])
					state_next.arm = nps_pkg::NPS_ARM_ZERO_SEEN;
				else if (sysref_rise && !wr_sync)
					state_next.arm = nps_pkg::NPS_ARM_IDLE;
			end
			default:
				state_next.arm = nps_pkg::NPS_ARM_IDLE;
		endcase
		// The armed flag is kept in its own flop so the output needs no decode.
		state_next.armed = (state_next.arm == nps_pkg::NPS_ARM_ARMED);
		// Reads return the stored value; reserved bits and unmapped addresses read zero.
		if (reg_req_i.rd)
		begin
			unique case (reg_req_i.addr)
				nps_pkg::NPS_ADDR_RDIV_LO:
					state_next.rdata = state_reg.nco_reference_divisor[7:0];
				nps_pkg::NPS_ADDR_RDIV_HI:
					state_next.rdata = state_reg.nco_reference_divisor[15:8];
				nps_pkg::NPS_ADDR_SYNC:
					state_next.rdata = {6'h00, state_reg.phase_init_on_sync_request,
						state_reg.phase_init_on_next_sysref};
				default:
					state_next.rdata = 8'h00;
			endcase
		end
	end

	// State register; reset leaves the arming sequence idle.
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_reg <= '0;
			state_reg.nco_reference_divisor <= nps_pkg::NPS_RDIV_RESET;
			state_reg.phase_init_on_sync_request <= nps_pkg::NPS_SYNC_RESET[1];
			state_reg.phase_init_on_next_sysref <= nps_pkg::NPS_SYNC_RESET[0];
			state_reg.arm <= nps_pkg::NPS_ARM_IDLE;
			state_reg.sync_prev <= 1'b1;
		end
		else
			state_reg <= state_next;
	end

	// The accumulator sees one divisor regardless of the preset selected upstream.
	nps_phase_acc u_acc
	(
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.init_i(state_reg.phase_init),
		.rdiv_i(state_reg.nco_reference_divisor),
		.cfg_i(nco_cfg_i),
		.phase_o(phase_o)
	);

	assign reg_rdata_o = state_reg.rdata;
	assign reg_rvalid_o = state_reg.rvalid;
	assign phase_init_o = state_reg.phase_init;
	assign sync_armed_o = state_reg.armed;
	assign link_sync_request_o = state_reg.link_sync_request;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	// A pending SYNC~ rise meets a boundary and the init pulse follows one cycle later.
	property p_sync_init;
		(state_reg.phase_init_on_sync_request && state_reg.sync_pending && lmfc_boundary_i)
		|=> phase_init_o;
	endproperty
	a_sync_init: assert property (p_sync_init) else $error("missing SYNC init");

	// With sync-request init cleared, SYNC~ alone never makes an init.
	property p_sync_off;
		(!state_reg.phase_init_on_sync_request && !sync_armed_o) ##1
		(!state_reg.phase_init_on_sync_request && !sync_armed_o) |=> !phase_init_o;
	endproperty
	a_sync_off: assert property (p_sync_off) else $error("init without cause");

	// In 64b/66b the link request stays low whatever SYNC~ does.
	property p_link_untouched;
		encoding_64b66b_i |=> !link_sync_request_o;
	endproperty
	a_link_untouched: assert property (p_link_untouched) else $error("SYNC changed link");

	// Zero write, an idle cycle, then a one write arms the block.
	property p_arm_seq;
		(wr_sync && !reg_req_i.wdata[0]) ##1 !wr_sync ##1 (wr_sync && reg_req_i.wdata[0])
		|=> sync_armed_o;
	endproperty
	a_arm_seq: assert property (p_arm_seq) else $error("arm sequence failed");

	// An armed SYSREF rise makes exactly one init and disarms.
	property p_first_edge;
		(sync_armed_o && sysref_i && !state_reg.sysref_prev && !wr_sync)
		|=> (phase_init_o && !sync_armed_o);
	endproperty
	a_first_edge: assert property (p_first_edge) else $error("SYSREF edge not taken");

	// Unarmed without a one write the block stays unarmed, including after reset.
	property p_stay_disarmed;
		(!sync_armed_o && !wr_sync) |=> !sync_armed_o;
	endproperty
	a_stay_disarmed: assert property (p_stay_disarmed) else $error("armed spuriously");

	// Once consumed, later SYSREF rises without SYNC init give no pulse in the cycle after two quiet cycles.
	property p_ignore_later;
		(!sync_armed_o && !state_reg.phase_init_on_sync_request && !wr_sync)
		##1 (!state_reg.phase_init_on_sync_request && !wr_sync) |=> !phase_init_o;
	endproperty
	a_ignore_later: assert property (p_ignore_later) else $error("SYSREF re-inited");

	// A low-byte write lands in the shared divisor.
	property p_rdiv_write;
		(reg_req_i.wr && reg_req_i.addr == nps_pkg::NPS_ADDR_RDIV_LO)
		|=> (state_reg.nco_reference_divisor[7:0] == $past(reg_req_i.wdata));
	endproperty
	a_rdiv_write: assert property (p_rdiv_write) else $error("divisor write lost");

	c_sync_init: cover property (init_sync);
	c_sysref_init: cover property (init_sysref);
	c_rearm: cover property (init_sysref ##[1:20] sync_armed_o);
	c_64b66b_sync: cover property (encoding_64b66b_i && init_sync);

endmodule

//--- verif/nps_far_end.sv
// Model of the SYSREF source, the receiver driving SYNC~ and the frame boundary timer.
`timescale 1ns/1ps

module nps_far_end
(
	input wire logic sys_clk_i,
	output logic sync_n_o,
	output logic sysref_o,
	output logic lmfc_boundary_o
);
	logic [2:0] frame_cnt;

	// Lines start idle: no sync request, SYSREF quiet.
	initial
	begin
		sync_n_o = 1'h1;
		sysref_o = 1'h0;
		lmfc_boundary_o = 1'h0;
		frame_cnt = 3'h0;
	end

	// The frame timer runs free, so a boundary comes every eight cycles.
	always @(posedge sys_clk_i)
	begin
		frame_cnt <= frame_cnt + 3'h1;
		lmfc_boundary_o <= (frame_cnt == 3'h7);
	end

	// The receiver sets its request level just after an edge.
	task automatic drive_sync(input logic level);
		@(posedge sys_clk_i);
		sync_n_o <= level;
	endtask

	// A burst of SYSREF pulses; the device may only act on the first rise.
	task automatic sysref_burst(input int pulses);
		repeat (pulses)
		begin
			@(posedge sys_clk_i);
			sysref_o <= 1'h1;
			repeat (2) @(posedge sys_clk_i);
			sysref_o <= 1'h0;
			repeat (3) @(posedge sys_clk_i);
		end
	endtask
endmodule

//--- verif/nps_nco_phase_sync_control_bench.sv
// Self-checking bench of the NCO phase sync and reference divisor block.
`timescale 1ns/1ps

module nps_nco_phase_sync_control_bench;
	logic sys_clk_i, nrst_i, encoding_64b66b_i, sync_n, sysref, lmfc;
	nps_pkg::nps_reg_req_s reg_req_i;
	nps_pkg::nps_nco_cfg_s nco_cfg_i;
	logic [7:0] reg_rdata_o;
	logic reg_rvalid_o, phase_init_o, sync_armed_o, link_sync_request_o;
	logic [31:0] phase_o;
	logic [31:0] p0;
	int miscompares, comparisons, inits, n;

	nps_far_end nps_far_end_i (.sys_clk_i(sys_clk_i), .sync_n_o(sync_n), .sysref_o(sysref),
		.lmfc_boundary_o(lmfc));
	nps_nco_phase_sync_control nps_nco_phase_sync_control_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_req_i(reg_req_i),
		.sync_n_i(sync_n), .sysref_i(sysref), .lmfc_boundary_i(lmfc),
		.encoding_64b66b_i(encoding_64b66b_i), .nco_cfg_i(nco_cfg_i),
		.reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .phase_o(phase_o),
		.phase_init_o(phase_init_o), .sync_armed_o(sync_armed_o),
		.link_sync_request_o(link_sync_request_o));

	// Free-running 10 MHz clock.
	initial
	begin
		sys_clk_i = 1'h0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end

	// Init pulses are counted so that extra or missing ones show up.
	always @(posedge sys_clk_i)
		if (phase_init_o === 1'h1)
			inits <= inits + 1;

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test();
		if (miscompares == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic do_reset();
		@(posedge sys_clk_i);
		nrst_i <= 1'h0;
		repeat (3) @(posedge sys_clk_i);
		nrst_i <= 1'h1;
		#1;
	endtask

	// A write is taken at the edge after it is raised; the strobe drops at that edge.
	task automatic reg_write(input logic [15:0] addr, input logic [7:0] data);
		@(posedge sys_clk_i);
		reg_req_i <= '{1'h1, 1'h0, addr, data};
		@(posedge sys_clk_i);
		reg_req_i <= '0;
		#1;
	endtask

	// Read data is looked at only in the one cycle that rvalid stands.
	task automatic reg_check(input logic [15:0] addr, input logic [7:0] exp);
		@(posedge sys_clk_i);
		reg_req_i <= '{1'h0, 1'h1, addr, 8'h00};
		@(posedge sys_clk_i);
		reg_req_i <= '0;
		#1;
		check("rvalid", 32'h1, {31'h0, reg_rvalid_o});
		check("rdata", {24'h0, exp}, {24'h0, reg_rdata_o});
	endtask

	// Waits a bounded time for an init pulse; running out ends the run as a failure.
	task automatic wait_init();
		for (int i = 0; i < 40 && phase_init_o !== 1'h1; i++)
		begin
			@(posedge sys_clk_i);
			#1;
		end
		if (phase_init_o !== 1'h1)
		begin
			miscompares++;
			stop_test();
		end
	endtask

	task automatic sync_init_pulse();
		nps_far_end_i.drive_sync(1'h0);
		nps_far_end_i.drive_sync(1'h1);
		wait_init();
		@(posedge sys_clk_i);
		#1;
	endtask

	task automatic t_reset_values();
		reg_check(16'h0217, 8'h00);
		reg_check(16'h0218, 8'h00);
		reg_check(16'h0219, 8'h02);
		reg_check(16'h021A, 8'h00);
		check("armed", 32'h0, {31'h0, sync_armed_o});
	endtask

	// SYNC~ init in 8b/10b, then the plain accumulator step with divisor zero.
	task automatic t_sync_init();
		nps_far_end_i.drive_sync(1'h0);
		@(posedge sys_clk_i);
		#1;
		check("link req", 32'h1, {31'h0, link_sync_request_o});
		nps_far_end_i.drive_sync(1'h1);
		wait_init();
		@(posedge sys_clk_i);
		#1;
		check("phase", 32'hA5C30000, phase_o);
		@(posedge sys_clk_i);
		#1;
		check("phase step", 32'hA5C30000 + 32'h01000000, phase_o);
	endtask

	// Divisor four makes the phase repeat every four cycles.
	task automatic t_divisor();
		reg_write(16'h0217, 8'h04);
		reg_write(16'h0218, 8'h1F);
		reg_check(16'h0218, 8'h1F);
		reg_write(16'h0218, 8'h00);
		sync_init_pulse();
		p0 = phase_o;
		repeat (4) @(posedge sys_clk_i);
		#1;
		check("wrap", p0, phase_o);
		reg_write(16'h0217, 8'h00);
	endtask

	// A new frequency and offset take hold cleanly once sync is run again.
	task automatic t_retune();
		@(posedge sys_clk_i);
		nco_cfg_i <= '{32'h00345678, 16'h1E0F};
		sync_init_pulse();
		check("retuned phase", 32'h1E0F0000, phase_o);
		@(posedge sys_clk_i);
		#1;
		check("retuned step", 32'h1E0F0000 + 32'h00345678, phase_o);
	endtask

	// In 64b/66b SYNC~ still inits the phase but never reaches the link.
	task automatic t_64b();
		@(posedge sys_clk_i);
		encoding_64b66b_i <= 1'h1;
		nps_far_end_i.drive_sync(1'h0);
		@(posedge sys_clk_i);
		#1;
		check("link req 64b", 32'h0, {31'h0, link_sync_request_o});
		nps_far_end_i.drive_sync(1'h1);
		wait_init();
		// One more edge lets the init counter take this pulse before the next scenario.
		@(posedge sys_clk_i);
		encoding_64b66b_i <= 1'h0;
		#1;
	endtask

	// Arm by zero then one; a burst inits once; SYNC~ is ignored with its bit clear.
	task automatic t_sysref();
		n = inits;
		reg_write(16'h0219, 8'h00);
		check("armed early", 32'h0, {31'h0, sync_armed_o});
		reg_write(16'h0219, 8'h01);
		check("armed", 32'h1, {31'h0, sync_armed_o});
		reg_check(16'h0219, 8'h01);
		nps_far_end_i.drive_sync(1'h0);
		nps_far_end_i.drive_sync(1'h1);
		repeat (20) @(posedge sys_clk_i);
		check("sync ignored", n, inits);
		nps_far_end_i.sysref_burst(3);
		check("one init", n + 1, inits);
		check("disarmed", 32'h0, {31'h0, sync_armed_o});
		reg_write(16'h0219, 8'h00);
		reg_write(16'h0219, 8'h01);
		nps_far_end_i.sysref_burst(1);
		check("rearmed init", n + 2, inits);
	endtask

	// A reset in mid-run drops the arming.
	task automatic t_reset_arm();
		reg_write(16'h0219, 8'h00);
		reg_write(16'h0219, 8'h01);
		do_reset();
		check("armed after reset", 32'h0, {31'h0, sync_armed_o});
		n = inits;
		nps_far_end_i.sysref_burst(1);
		check("no init", n, inits);
		reg_check(16'h0219, 8'h02);
	endtask

	initial
	begin
		nrst_i = 1'h0;
		reg_req_i = '0;
		encoding_64b66b_i = 1'h0;
		nco_cfg_i = '{32'h01000000, 16'hA5C3};
		miscompares = 0;
		comparisons = 0;
		inits = 0;
		do_reset();
		t_reset_values();
		t_sync_init();
		t_divisor();
		t_retune();
		t_64b();
		t_sysref();
		t_reset_arm();
		stop_test();
	end
endmodule
